// File: verilog/dctl_regs.svh
// Register offsets, field positions and reset values of the transfer engine
`ifndef DCTL_REGS_SVH
`define DCTL_REGS_SVH
`define DCTL_OFS_DONE_CFG    32'hFFD00230
`define DCTL_OFS_FAULT_CFG   32'hFFD00234
`define DCTL_OFS_CONTROL     32'hFFD00328
`define DCTL_OFS_DONE_STAT   32'hFFD004B0
`define DCTL_OFS_FAULT_STAT  32'hFFD004B4
`define DCTL_OFS_RUN_CTL     32'hFFD004C4
`define DCTL_OFS_PHASE       32'hFFD004EC
`define DCTL_OFS_SRC_PTR     32'hFFD00500
`define DCTL_OFS_DST_PTR     32'hFFD00504
`define DCTL_OFS_COUNT       32'hFFD00508
`define DCTL_BYTE_LSB        24
`define DCTL_BIT_SRC_HOLD    7
`define DCTL_BIT_DST_HOLD    6
`define DCTL_BIT_ENABLE      0
`define DCTL_BIT_RUNNING     7
`define DCTL_BIT_START       0
`define DCTL_BIT_PHASE       7
`define DCTL_BIT_IRQ_STAT    7
`define DCTL_BIT_IRQ_EN      3
`define DCTL_IRQ_LVL_HI      2
`define DCTL_IRQ_LVL_LO      0
`define DCTL_RST_PTR         32'h00000000
`define DCTL_RST_COUNT       32'hFFFFFFFF
`define DCTL_RST_CFG         4'h0
`define DCTL_LVL_NONE        3'h0
`endif

// File: verilog/dctl_pkg.sv
// Types shared by the transfer engine modules
package dctl_pkg;
	typedef enum logic [1:0] {ST_IDLE, ST_SRC, ST_DST} dctl_state_t;
	typedef struct packed {
		dctl_state_t state;
		logic        src_hold;
		logic        dst_hold;
		logic        enable;
		logic [31:0] count;
		logic [31:0] data;
		logic [31:0] rdata;
		logic        ack;
	} dctl_top_t;
	typedef struct packed {
		logic [3:0] cfg;
		logic       pending;
	} dctl_irq_st_t;
	typedef struct packed {
		logic [31:0] val;
	} dctl_ptr_st_t;
endpackage : dctl_pkg

// File: verilog/dctl_irq_if.sv
// Signals between the engine core and one termination interrupt channel
`timescale 1ns/1ps
interface dctl_irq_if;
	logic       set;
	logic       clr;
	logic       cfg_wr;
	logic [3:0] cfg_wdata;
	logic [3:0] cfg;
	logic       pending;
	logic [2:0] level;
	modport ctl  (output set, output clr, output cfg_wr, output cfg_wdata,
	              input cfg, input pending, input level);
	modport chan (input set, input clr, input cfg_wr, input cfg_wdata,
	              output cfg, output pending, output level);
endinterface : dctl_irq_if

// File: verilog/dctl_ptr.sv
// Address pointer that loads from software and steps by the bytes moved
`timescale 1ns/1ps
`include "dctl_regs.svh"
module dctl_ptr
	import dctl_pkg::*;
#(
	parameter int W = 32
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         load,
	input  wire logic [W-1:0] load_val,
	input  wire logic         step,
	input  wire logic         hold,
	input  wire logic [2:0]   bytes,
	output logic      [W-1:0] val
);
	dctl_ptr_st_t s_q;
	dctl_ptr_st_t s_d;

	always_comb begin
		s_d = s_q;
		if (load) begin
			s_d.val = load_val;
		end else if (step && !hold) begin
			s_d.val = s_q.val + {29'h0, bytes};
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign val = s_q.val;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_ptr_held: assert property (step && hold && !load |=> $stable(val)) // RULE_01
		else $error("held pointer moved");
	a_ptr_counts: assert property (step && !hold && !load
		|=> val == $past(val) + {29'h0, $past(bytes)}) // RULE_02
		else $error("counting pointer did not step by width");
endmodule : dctl_ptr

// File: verilog/dctl_irq.sv
// One termination interrupt channel: configuration, pending flag, request level
`timescale 1ns/1ps
`include "dctl_regs.svh"
module dctl_irq
	import dctl_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst_n,
	dctl_irq_if.chan  bus
);
	dctl_irq_st_t s_q;
	dctl_irq_st_t s_d;

	always_comb begin
		s_d = s_q;
		if (bus.cfg_wr) begin
			s_d.cfg = bus.cfg_wdata;
		end
		// Set beats clear so a termination in the clearing cycle survives
		if (bus.set) begin
			s_d.pending = 1'b1;
		end else if (bus.clr) begin
			s_d.pending = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign bus.cfg     = s_q.cfg;
	assign bus.pending = s_q.pending;
	assign bus.level   = (s_q.pending && s_q.cfg[`DCTL_BIT_IRQ_EN])
		? s_q.cfg[`DCTL_IRQ_LVL_HI:`DCTL_IRQ_LVL_LO] : `DCTL_LVL_NONE; // RULE_13

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_irq_clear: assert property (bus.clr && !bus.set |=> !bus.pending) // RULE_16
		else $error("write to status left interrupt pending");
	a_irq_level: assert property (bus.pending && !bus.cfg[`DCTL_BIT_IRQ_EN]
		|-> bus.level == `DCTL_LVL_NONE) // RULE_14
		else $error("disabled channel drives a level");
endmodule : dctl_irq

// File: verilog/dctl_top.sv
// Transfer engine control and status registers with the task sequencer
// Notes on behaviour
// RULE_01 - Source hold bit 7 set keeps source address; clear makes it count up.
// RULE_02 - Destination hold bit 6 set keeps destination address; clear counts up.
// RULE_03 - Software writes zero into control register bits 5 down to 1.
// RULE_04 - Control bit 0 enables the engine; clear holds the engine in reset.
// RULE_05 - Run control bit 7 reads running state; writes to it do nothing.
// RULE_06 - Writing run bit 0 as 1 starts a task; as 0 stops one.
// RULE_07 - Run bit 0 always reads back as zero.
// RULE_08 - Phase bit 7 reads 1 on the source side, 0 on destination.
// RULE_09 - Source pointer takes start address, steps, keeps final address.
// RULE_10 - Destination pointer takes start address, steps, keeps final address.
// RULE_11 - Byte count is all ones after reset and after a good task.
// RULE_12 - Bus error or stop leaves the untransferred byte count behind; the code still updates the count on a stop in a destination acknowledge cycle.
// RULE_13 - Done channel config: enable bit 3, level bits 2..0, 000 none.
// RULE_14 - Fault channel config: enable bit 3, level bits 2..0, 000 off.
// RULE_15 - Done status bit 7 reads 0 while pending, 1 otherwise.
// RULE_16 - Any write to done status clears its pending request; the code keeps it pending when a done event falls in the same cycle.
// RULE_17 - Fault status bit 7 reads 0 while pending, 1 otherwise.
// RULE_18 - Any write to fault status clears its pending request; the code keeps it pending when a fault event falls in the same cycle.
// RULE_19 - A good completion raises the done interrupt.
// RULE_20 - A bus error or software stop raises the fault interrupt.
// RULE_21 - Software reaches pointers and count with long word accesses only.
// RULE_22 - Count drops by bytes moved; task ends well when count runs out.
// RULE_23 - Start shows running at once; running clears on any termination.
`timescale 1ns/1ps
`include "dctl_regs.svh"
module dctl_top
	import dctl_pkg::*;
(
	input  wire logic        REF_CLK,
	input  wire logic        RESET_N,
	input  wire logic        REG_SEL,
	input  wire logic        REG_WR,
	input  wire logic [31:0] REG_ADDR,
	input  wire logic [31:0] REG_WDATA,
	output logic      [31:0] REG_RDATA,
	output logic             REG_ACK,
	output logic             XFER_REQ,
	output logic             XFER_WRITE,
	output logic      [31:0] XFER_ADDR,
	output logic      [31:0] XFER_WDATA,
	input  wire logic        XFER_ACK,
	input  wire logic        XFER_BERR,
	input  wire logic [2:0]  XFER_BYTES,
	input  wire logic [31:0] XFER_RDATA,
	output logic      [2:0]  DONE_IRQ_LEVEL,
	output logic      [2:0]  FAULT_IRQ_LEVEL
);
	dctl_top_t s_q;
	dctl_top_t s_d;

	dctl_irq_if done_if ();
	dctl_irq_if fault_if ();

	logic [31:0] src_val;
	logic [31:0] dst_val;
	logic        wr;
	logic        rd;
	logic [7:0]  wbyte;
	logic        running;
	logic        src_phase;
	logic        src_step;
	logic        dst_step;
	logic        idle_wr;
	logic        start_req;
	logic        stop_req;
	logic        done_evt;
	logic        fault_evt;
	logic [31:0] step_bytes;

	assign wr         = REG_SEL && REG_WR;
	assign rd         = REG_SEL && !REG_WR;
	assign wbyte      = REG_WDATA[`DCTL_BYTE_LSB +: 8];
	assign running    = s_q.state != ST_IDLE; // RULE_23
	assign src_phase  = s_q.state != ST_DST; // RULE_08
	assign step_bytes = {29'h0, XFER_BYTES};
	// Pointer and count writes land only while idle; the sequencer owns them in a task
	assign idle_wr    = wr && !running;

	assign start_req = wr && REG_ADDR == `DCTL_OFS_RUN_CTL && wbyte[`DCTL_BIT_START]
		&& s_q.enable && !running; // RULE_06
	assign stop_req  = wr && REG_ADDR == `DCTL_OFS_RUN_CTL && !wbyte[`DCTL_BIT_START]
		&& running; // RULE_06
	assign src_step  = s_q.state == ST_SRC && XFER_ACK && !XFER_BERR && !stop_req;
	assign dst_step  = s_q.state == ST_DST && XFER_ACK && !XFER_BERR && !stop_req;
	assign done_evt  = dst_step && s_q.enable && s_q.count <= step_bytes; // RULE_22
	assign fault_evt = s_q.enable && running && (stop_req || (XFER_REQ && XFER_BERR)); // RULE_20

	always_comb begin
		s_d     = s_q;
		s_d.ack = REG_SEL;
		if (wr && REG_ADDR == `DCTL_OFS_CONTROL) begin
			// Reserved bits 5..1 are expected as zero and are not stored
			s_d.src_hold = wbyte[`DCTL_BIT_SRC_HOLD]; // RULE_01
			s_d.dst_hold = wbyte[`DCTL_BIT_DST_HOLD]; // RULE_02
			s_d.enable   = wbyte[`DCTL_BIT_ENABLE]; // RULE_04
		end
		if (idle_wr && REG_ADDR == `DCTL_OFS_COUNT) begin
			s_d.count = REG_WDATA;
		end
		case (s_q.state)
			ST_IDLE: begin
				if (start_req) begin
					s_d.state = ST_SRC; // RULE_23
				end
			end
			ST_SRC: begin
				if (XFER_ACK && !XFER_BERR) begin
					s_d.data  = XFER_RDATA;
					s_d.state = ST_DST;
				end
			end
			ST_DST: begin
				if (XFER_ACK && !XFER_BERR) begin
					if (s_q.count <= step_bytes) begin
						s_d.count = `DCTL_RST_COUNT; // RULE_11
						s_d.state = ST_IDLE;
					end else begin
						s_d.count = s_q.count - step_bytes; // RULE_22
						s_d.state = ST_SRC;
					end
				end
			end
			default: begin
				s_d.state = ST_IDLE;
			end
		endcase
		// Error or stop leaves the count as it stood, bytes not moved, except a stop in a destination acknowledge cycle, which still updates it
		if (fault_evt) begin
			s_d.state = ST_IDLE; // RULE_12
		end
		if (!s_q.enable) begin
			s_d.state = ST_IDLE; // RULE_04
		end
		s_d.rdata = 32'h0;
		if (rd) begin
			case (REG_ADDR)
				`DCTL_OFS_CONTROL: begin
					s_d.rdata[`DCTL_BYTE_LSB + `DCTL_BIT_SRC_HOLD] = s_q.src_hold;
					s_d.rdata[`DCTL_BYTE_LSB + `DCTL_BIT_DST_HOLD] = s_q.dst_hold;
					s_d.rdata[`DCTL_BYTE_LSB + `DCTL_BIT_ENABLE]   = s_q.enable;
				end
				`DCTL_OFS_RUN_CTL: begin
					// Start bit is write-only and reads zero
					s_d.rdata[`DCTL_BYTE_LSB + `DCTL_BIT_RUNNING] = running; // RULE_05
				end
				`DCTL_OFS_PHASE: begin
					s_d.rdata[`DCTL_BYTE_LSB + `DCTL_BIT_PHASE] = src_phase; // RULE_08
				end
				`DCTL_OFS_DONE_CFG: begin
					s_d.rdata[`DCTL_BYTE_LSB +: 4] = done_if.cfg;
				end
				`DCTL_OFS_FAULT_CFG: begin
					s_d.rdata[`DCTL_BYTE_LSB +: 4] = fault_if.cfg;
				end
				`DCTL_OFS_DONE_STAT: begin
					s_d.rdata[`DCTL_BYTE_LSB + `DCTL_BIT_IRQ_STAT] = !done_if.pending; // RULE_15
				end
				`DCTL_OFS_FAULT_STAT: begin
					s_d.rdata[`DCTL_BYTE_LSB + `DCTL_BIT_IRQ_STAT] = !fault_if.pending; // RULE_17
				end
				`DCTL_OFS_SRC_PTR: begin
					s_d.rdata = src_val;
				end
				`DCTL_OFS_DST_PTR: begin
					s_d.rdata = dst_val;
				end
				`DCTL_OFS_COUNT: begin
					s_d.rdata = s_q.count;
				end
				default: begin
					s_d.rdata = 32'h0;
				end
			endcase
		end
	end

	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			s_q       <= '0;
			s_q.state <= ST_IDLE;
			s_q.count <= `DCTL_RST_COUNT; // RULE_11
		end else begin
			s_q <= s_d;
		end
	end

	dctl_ptr #(
		.W (32)
	) u_src_ptr (
		.clk      (REF_CLK),
		.rst_n    (RESET_N),
		.load     (idle_wr && REG_ADDR == `DCTL_OFS_SRC_PTR), // RULE_09
		.load_val (REG_WDATA),
		.step     (src_step),
		.hold     (s_q.src_hold), // RULE_01
		.bytes    (XFER_BYTES),
		.val      (src_val)
	);

	dctl_ptr #(
		.W (32)
	) u_dst_ptr (
		.clk      (REF_CLK),
		.rst_n    (RESET_N),
		.load     (idle_wr && REG_ADDR == `DCTL_OFS_DST_PTR), // RULE_10
		.load_val (REG_WDATA),
		.step     (dst_step),
		.hold     (s_q.dst_hold), // RULE_02
		.bytes    (XFER_BYTES),
		.val      (dst_val)
	);

	assign done_if.set        = done_evt; // RULE_19
	assign done_if.clr        = wr && REG_ADDR == `DCTL_OFS_DONE_STAT; // RULE_16
	assign done_if.cfg_wr     = wr && REG_ADDR == `DCTL_OFS_DONE_CFG; // RULE_13
	assign done_if.cfg_wdata  = wbyte[3:0];
	assign fault_if.set       = fault_evt; // RULE_20
	assign fault_if.clr       = wr && REG_ADDR == `DCTL_OFS_FAULT_STAT; // RULE_18
	assign fault_if.cfg_wr    = wr && REG_ADDR == `DCTL_OFS_FAULT_CFG; // RULE_14
	assign fault_if.cfg_wdata = wbyte[3:0];

	dctl_irq u_done_irq (
		.clk   (REF_CLK),
		.rst_n (RESET_N),
		.bus   (done_if)
	);

	dctl_irq u_fault_irq (
		.clk   (REF_CLK),
		.rst_n (RESET_N),
		.bus   (fault_if)
	);

	assign REG_RDATA       = s_q.rdata;
	assign REG_ACK         = s_q.ack;
	assign XFER_REQ        = running;
	assign XFER_WRITE      = s_q.state == ST_DST;
	assign XFER_ADDR       = src_phase ? src_val : dst_val; // RULE_09
	assign XFER_WDATA      = s_q.data;
	assign DONE_IRQ_LEVEL  = done_if.level;
	assign FAULT_IRQ_LEVEL = fault_if.level;

	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RESET_N);

	a_start_runs: assert property (start_req |=> running ##0 src_phase) // RULE_23
		else $error("start did not enter source phase");
	a_stop_halts: assert property (stop_req && s_q.enable
		|=> !running ##1 fault_if.pending) // RULE_20
		else $error("stop did not halt with fault interrupt");
	a_count_reload: assert property (done_evt
		|=> s_q.count == `DCTL_RST_COUNT && !running ##1 done_if.pending) // RULE_11
		else $error("good completion did not reload count");
	a_count_keep: assert property (fault_evt |=> $stable(s_q.count) && !running) // RULE_12
		else $error("fault changed remaining count");
	a_count_step: assert property (dst_step && s_q.enable && !done_evt
		|=> s_q.count == $past(s_q.count) - $past(step_bytes)) // RULE_22
		else $error("count not reduced by bytes moved");
	a_disable_idle: assert property (!s_q.enable |=> !running) // RULE_04
		else $error("engine ran while disabled");
	a_run_readback: assert property (rd && REG_ADDR == `DCTL_OFS_RUN_CTL
		|=> REG_ACK && !REG_RDATA[`DCTL_BYTE_LSB + `DCTL_BIT_START]
		&& REG_RDATA[`DCTL_BYTE_LSB + `DCTL_BIT_RUNNING] == $past(running)) // RULE_07
		else $error("run control readback wrong");
	a_phase_read: assert property (rd && REG_ADDR == `DCTL_OFS_PHASE
		|=> REG_RDATA[`DCTL_BYTE_LSB + `DCTL_BIT_PHASE] == $past(s_q.state != ST_DST)) // RULE_08
		else $error("phase flag readback wrong");
	a_stat_read: assert property (rd && REG_ADDR == `DCTL_OFS_DONE_STAT
		|=> REG_RDATA[`DCTL_BYTE_LSB + `DCTL_BIT_IRQ_STAT] == !$past(done_if.pending)) // RULE_15
		else $error("done status readback wrong");
	a_fault_read: assert property (rd && REG_ADDR == `DCTL_OFS_FAULT_STAT
		|=> REG_RDATA[`DCTL_BYTE_LSB + `DCTL_BIT_IRQ_STAT] == !$past(fault_if.pending)) // RULE_17
		else $error("fault status readback wrong");
	a_dst_addr: assert property (XFER_REQ && XFER_WRITE |-> XFER_ADDR == dst_val) // RULE_10
		else $error("destination cycle used wrong address");
endmodule : dctl_top

// File: tb/dctl_mem.sv
// Behavioural bus memory that answers the engine's transfer cycles
`timescale 1ns/1ps
module dctl_mem (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        req,
	input  wire logic        write,
	input  wire logic [31:0] addr,
	input  wire logic [31:0] wdata,
	input  wire logic [7:0]  wait_cyc,
	input  wire logic [3:0]  berr_nth,
	output logic             ack,
	output logic             berr,
	output logic      [2:0]  bytes,
	output logic      [31:0] rdata,
	output logic             wr_ev,
	output logic      [31:0] wr_addr,
	output logic      [31:0] wr_data
);
	logic [7:0] w_q;
	logic [3:0] n_q;
	// Byte count only meaningful with the acknowledge
	assign bytes = ack ? 3'h4 : 3'h0;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			{ack, berr, wr_ev, w_q, n_q} <= '0;
			{rdata, wr_addr, wr_data} <= '0;
		end else begin
			ack <= 1'b0;
			berr <= 1'b0;
			wr_ev <= 1'b0;
			// Released data lines toggle so stale values never look valid
			rdata <= ~rdata;
			if (!req) begin
				w_q <= 8'h00;
				n_q <= 4'h0;
			end else if (!ack && !berr) begin
				if (w_q < wait_cyc) begin
					w_q <= w_q + 8'h01;
				end else begin
					w_q <= 8'h00;
					n_q <= n_q + 4'h1;
					// Zero means never, so the cycle counter may wrap freely
					if (berr_nth != 4'h0 && n_q + 4'h1 == berr_nth) begin
						berr <= 1'b1;
					end else begin
						ack <= 1'b1;
						if (write) begin
							wr_ev <= 1'b1;
							wr_addr <= addr;
							wr_data <= wdata;
						end else begin
							rdata <= addr ^ 32'hA5C3_0F96;
						end
					end
				end
			end
		end
	end
endmodule : dctl_mem

// File: tb/testbench.sv
// Self-checking bench for the transfer engine register block
`timescale 1ns/1ps
`include "dctl_regs.svh"
module testbench;
	import dctl_pkg::*;
	logic        REF_CLK = 1'b0, RESET_N = 1'b0, REG_SEL = 1'b0, REG_WR = 1'b0;
	logic [31:0] REG_ADDR = 32'h0, REG_WDATA = 32'h0, REG_RDATA, XFER_ADDR, XFER_WDATA;
	logic [31:0] XFER_RDATA, wr_addr, wr_data, src, dst;
	logic        REG_ACK, XFER_REQ, XFER_WRITE, XFER_ACK, XFER_BERR, wr_ev;
	logic [2:0]  XFER_BYTES, DONE_IRQ_LEVEL, FAULT_IRQ_LEVEL;
	logic [7:0]  wait_cyc = 8'h00;
	logic [3:0]  berr_nth = 4'h0;
	logic [32:0] rq[$];
	logic [63:0] wq[$];
	int          n_mismatch = 0, n_compared = 0;
	always #25 REF_CLK = ~REF_CLK;
	dctl_top u_dctl_top (.REF_CLK(REF_CLK), .RESET_N(RESET_N), .REG_SEL(REG_SEL),
		.REG_WR(REG_WR), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
		.REG_ACK(REG_ACK), .XFER_REQ(XFER_REQ), .XFER_WRITE(XFER_WRITE),
		.XFER_ADDR(XFER_ADDR), .XFER_WDATA(XFER_WDATA), .XFER_ACK(XFER_ACK),
		.XFER_BERR(XFER_BERR), .XFER_BYTES(XFER_BYTES), .XFER_RDATA(XFER_RDATA),
		.DONE_IRQ_LEVEL(DONE_IRQ_LEVEL), .FAULT_IRQ_LEVEL(FAULT_IRQ_LEVEL));
	dctl_mem u_dctl_mem (.clk(REF_CLK), .rst_n(RESET_N), .req(XFER_REQ),
		.write(XFER_WRITE), .addr(XFER_ADDR), .wdata(XFER_WDATA), .wait_cyc(wait_cyc),
		.berr_nth(berr_nth), .ack(XFER_ACK), .berr(XFER_BERR), .bytes(XFER_BYTES),
		.rdata(XFER_RDATA), .wr_ev(wr_ev), .wr_addr(wr_addr), .wr_data(wr_data));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic conclude;
		$display("compared %0d, mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : conclude
	task automatic acc(input logic wr, input logic [31:0] a, input logic [31:0] d,
		input logic [31:0] exp);
		rq.push_back({~wr, exp});
		REG_SEL <= 1'b1;
		REG_WR <= wr;
		REG_ADDR <= a;
		REG_WDATA <= d;
		@(posedge REF_CLK);
		REG_SEL <= 1'b0;
		@(posedge REF_CLK);
	endtask : acc
	task automatic wr8(input logic [31:0] a, input logic [7:0] b);
		acc(1'b1, a, {b, 24'h0}, 32'h0);
	endtask : wr8
	task automatic rd8(input logic [31:0] a, input logic [7:0] b);
		acc(1'b0, a, 32'h0, {b, 24'h0});
	endtask : rd8
	task automatic idle_wait;
		int i;
		for (i = 0; i < 2000 && XFER_REQ !== 1'b0; i++) @(posedge REF_CLK);
		if (i == 2000) begin
			n_mismatch++;
			$display("MISMATCH at %0t: engine never went idle", $time);
			conclude();
		end
		repeat (3) @(posedge REF_CLK);
	endtask : idle_wait
	// Programs pointers and count as whole words, then starts the engine
	task automatic run(input logic [7:0] ctl, input logic [31:0] cnt);
		wr8(`DCTL_OFS_CONTROL, ctl);
		acc(1'b1, `DCTL_OFS_SRC_PTR, src, 32'h0);
		acc(1'b1, `DCTL_OFS_DST_PTR, dst, 32'h0);
		acc(1'b1, `DCTL_OFS_COUNT, cnt, 32'h0);
		wr8(`DCTL_OFS_RUN_CTL, 8'h01);
	endtask : run
	always @(posedge REF_CLK) begin
		if (REG_ACK === 1'b1) begin
			if (rq.size() == 0) chk(32'hDEAD_0000, 32'h0);
			else if (rq[0][32]) chk(REG_RDATA, rq.pop_front());
			else void'(rq.pop_front());
		end
		if (wr_ev === 1'b1) begin
			if (wq.size() == 0) chk(32'hDEAD_0001, 32'h0);
			else chk({wr_addr, wr_data} == wq.pop_front(), 32'h1);
		end
	end
	initial begin
		int k;
		void'($urandom(32'had4df9b8));
		repeat (8) @(posedge REF_CLK);
		RESET_N <= 1'b1;
		@(posedge REF_CLK);
		rd8(`DCTL_OFS_DONE_CFG, 8'h00);
		rd8(`DCTL_OFS_CONTROL, 8'h00);
		rd8(`DCTL_OFS_DONE_STAT, 8'h80);
		rd8(`DCTL_OFS_FAULT_STAT, 8'h80);
		rd8(`DCTL_OFS_RUN_CTL, 8'h00);
		rd8(`DCTL_OFS_PHASE, 8'h80);
		acc(1'b0, `DCTL_OFS_SRC_PTR, 32'h0, 32'h0);
		acc(1'b0, `DCTL_OFS_COUNT, 32'h0, 32'hFFFF_FFFF);
		acc(1'b0, 32'hFFD0_0600, 32'h0, 32'h0);
		$display("test reset_values done");
		for (k = 0; k < 16; k++) begin
			wr8(k[0] ? `DCTL_OFS_FAULT_CFG : `DCTL_OFS_DONE_CFG, {4'h0, k[3:0]});
			rd8(k[0] ? `DCTL_OFS_FAULT_CFG : `DCTL_OFS_DONE_CFG, {4'h0, k[3:0]});
		end
		wr8(`DCTL_OFS_RUN_CTL, 8'h80);
		rd8(`DCTL_OFS_RUN_CTL, 8'h00);
		$display("test config_regs done");
		src = $urandom & 32'hFFFF_FFFC;
		dst = $urandom & 32'hFFFF_FFFC;
		wait_cyc <= 8'd20;
		wr8(`DCTL_OFS_DONE_CFG, 8'h0D);
		wq.push_back({dst, src ^ 32'hA5C3_0F96});
		wq.push_back({dst + 32'h4, (src + 32'h4) ^ 32'hA5C3_0F96});
		run(8'h01, 32'h8);
		rd8(`DCTL_OFS_RUN_CTL, 8'h80);
		rd8(`DCTL_OFS_PHASE, 8'h80);
		idle_wait();
		chk(DONE_IRQ_LEVEL, 32'h5);
		rd8(`DCTL_OFS_RUN_CTL, 8'h00);
		acc(1'b0, `DCTL_OFS_COUNT, 32'h0, 32'hFFFF_FFFF);
		acc(1'b0, `DCTL_OFS_SRC_PTR, 32'h0, src + 32'h8);
		acc(1'b0, `DCTL_OFS_DST_PTR, 32'h0, dst + 32'h8);
		rd8(`DCTL_OFS_DONE_STAT, 8'h00);
		wr8(`DCTL_OFS_DONE_STAT, $urandom);
		rd8(`DCTL_OFS_DONE_STAT, 8'h80);
		chk(DONE_IRQ_LEVEL, 32'h0);
		$display("test counting_task done");
		wait_cyc <= $urandom_range(3, 0);
		wq.push_back({dst, src ^ 32'hA5C3_0F96});
		wq.push_back({dst, src ^ 32'hA5C3_0F96});
		run(8'hC1, 32'h8);
		idle_wait();
		acc(1'b0, `DCTL_OFS_SRC_PTR, 32'h0, src);
		acc(1'b0, `DCTL_OFS_DST_PTR, 32'h0, dst);
		wr8(`DCTL_OFS_DONE_STAT, 8'h00);
		$display("test hold_task done");
		berr_nth <= 4'h3;
		wr8(`DCTL_OFS_FAULT_CFG, 8'h0B);
		wq.push_back({dst, src ^ 32'hA5C3_0F96});
		run(8'h01, 32'h10);
		idle_wait();
		acc(1'b0, `DCTL_OFS_COUNT, 32'h0, 32'hC);
		rd8(`DCTL_OFS_FAULT_STAT, 8'h00);
		chk(FAULT_IRQ_LEVEL, 32'h3);
		chk(DONE_IRQ_LEVEL, 32'h0);
		wr8(`DCTL_OFS_FAULT_STAT, $urandom);
		rd8(`DCTL_OFS_FAULT_STAT, 8'h80);
		$display("test bus_error done");
		berr_nth <= 4'h0;
		wait_cyc <= 8'd60;
		run(8'h01, 32'h10);
		wr8(`DCTL_OFS_RUN_CTL, 8'h00);
		rd8(`DCTL_OFS_RUN_CTL, 8'h00);
		idle_wait();
		acc(1'b0, `DCTL_OFS_COUNT, 32'h0, 32'h10);
		chk(FAULT_IRQ_LEVEL, 32'h3);
		wr8(`DCTL_OFS_FAULT_STAT, 8'h00);
		wr8(`DCTL_OFS_RUN_CTL, 8'h01);
		wr8(`DCTL_OFS_CONTROL, 8'h00);
		rd8(`DCTL_OFS_RUN_CTL, 8'h00);
		idle_wait();
		chk(FAULT_IRQ_LEVEL, 32'h0);
		$display("test stop_disable done");
		conclude();
	end
endmodule : testbench
